// ---- pkg/ufb_pkg.sv ----
package ufb_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CHAR_W = 8;
   localparam int STAT_W = 4;
   localparam int ENTRY_W = CHAR_W + STAT_W;
   localparam int INT_W = 16;
   localparam int FRAC_W = 6;
   localparam int LCTL_W = 8;
   localparam int DIV_W = INT_W + FRAC_W;
   localparam int CFG_W = DIV_W + LCTL_W;
   localparam int FIFO_DEPTH = 16;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFF_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_IDIV = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_FDIV = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_LCTL = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_CTL = 8'h14;

   // Control register fields and reset value
   localparam int CTL_EN = 0;
   localparam int CTL_TX = 8;
   localparam int CTL_RX = 9;
   localparam logic [DATA_W-1:0] CTL_RST = 32'h0000_0300;

   // Line control fields
   localparam int LC_PEN = 1;
   localparam int LC_EPS = 2;
   localparam int LC_STP2 = 3;
   localparam int LC_FIFO = 4;
   localparam int LC_WLEN = 5;
   localparam int LC_SPS = 7;

   // Flag register fields
   localparam int FL_BUSY = 3;
   localparam int FL_RXFE = 4;
   localparam int FL_TXFF = 5;
   localparam int FL_RXFF = 6;
   localparam int FL_TXFE = 7;

   // Receive entry status fields
   localparam int RS_FE = 8;
   localparam int RS_PE = 9;
   localparam int RS_BE = 10;
   localparam int RS_OE = 11;

   // Oversampling
   localparam logic [3:0] MID_TICK = 4'h7;
   localparam logic [3:0] LAST_TICK = 4'hF;
   localparam logic [2:0] MIN_LAST_BIT = 3'h4;
   localparam logic [DIV_W:0] FRAC_STEP = 23'h00_0040;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_DATA = 3'b010,
      ST_PAR = 3'b011,
      ST_STOP = 3'b100
   } ufb_state_t;
endpackage

// ---- pkg/ufb_fifo_if.sv ----
`timescale 1ns/1ps
interface ufb_fifo_if #(parameter int WIDTH = 8);
   logic push;
   logic pop;
   logic single;
   logic [WIDTH-1:0] push_data;
   logic [WIDTH-1:0] pop_data;
   logic full;
   logic empty;
   modport ctl (output push, pop, single, push_data,
                input pop_data, full, empty);
   modport mem (input push, pop, single, push_data,
                output pop_data, full, empty);
endinterface

// ---- rtl/ufb_fifo.sv ----
`timescale 1ns/1ps
module ufb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst,
   ufb_fifo_if.mem port
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   generate
      if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
         $error("FIFO depth must be a power of two of at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0] wr_ptr_reg, wr_ptr_next;
   logic [PW-1:0] rd_ptr_reg, rd_ptr_next;
   logic [CW-1:0] count_reg, count_next;
   logic [CW-1:0] limit;
   logic do_push, do_pop;

   // Disabled FIFO acts as a single holding register
   always_comb begin
      limit = port.single ? CW'(1) : CW'(DEPTH);
      port.full = (count_reg >= limit);
      port.empty = (count_reg == '0);
      port.pop_data = mem_reg[rd_ptr_reg];
      do_push = port.push && !port.full;
      do_pop = port.pop && !port.empty;
      wr_ptr_next = do_push ? wr_ptr_reg + PW'(1) : wr_ptr_reg;
      rd_ptr_next = do_pop ? rd_ptr_reg + PW'(1) : rd_ptr_reg;
      count_next = count_reg + CW'(do_push) - CW'(do_pop);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
      if (do_push) begin
         mem_reg[wr_ptr_reg] <= port.push_data;
      end
   end
endmodule

// ---- rtl/ufb_top.sv ----
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Transmit and receive enables set after reset
// - Disable mid-character finishes that character first
// - Frame: start, data LSB first, parity, stops
// - Receiver checks overrun, parity, framing, break
// - Divisor is 16-bit integer plus 6-bit fraction
// - Divisor equals clock over sixteen times baud
// - Oversample tick at 16x baud paces both directions after the start edge
// - Divisors and line settings latch on line write
// - 16-entry FIFOs, receive entries carry four flags
// - Enabled module sends until transmit FIFO empty
// - Busy from FIFO non-empty until stop sent
// - Busy stays while draining after disable
// - Start accepted only if low at eighth tick
// - Data bits sampled every sixteenth tick
// - Parity checked only when parity enabled
// - Stop must be high, else framing error
// - Completed character pushed with its error flags
// - Five to eight bits, parity modes, stop count
// - FIFOs single-entry until FIFO enable set
////////////////////////////////////////////////////////////////////////////
module ufb_top #(
   parameter int FIFO_DEPTH = ufb_pkg::FIFO_DEPTH
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [ufb_pkg::ADDR_W-1:0] ADDR,
   input wire logic [ufb_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [ufb_pkg::DATA_W-1:0] RDATA,
   input wire logic SERIAL_IN_PIN,
   output logic SERIAL_OUT_PIN
);
   import ufb_pkg::*;

   generate
      if (FIFO_DEPTH < 2) begin : g_bad_depth
         $error("FIFO_DEPTH must be at least 2");
      end
   endgenerate

   // Parity bit for the active character length and mode
   function automatic logic parity_of(input logic [CHAR_W-1:0] d,
                                      input logic [2:0] last,
                                      input logic eps,
                                      input logic sps);
      logic p;
      p = 1'b0;
      for (int i = 0; i < CHAR_W; i++) begin
         if (3'(i) <= last) begin
            p = p ^ d[i];
         end
      end
      parity_of = sps ? !eps : (p ^ !eps);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [DATA_W-1:0] ctl_reg, ctl_next;
   logic [INT_W-1:0] idiv_reg, idiv_next;
   logic [FRAC_W-1:0] fdiv_reg, fdiv_next;
   logic [CFG_W-1:0] cfg_reg, cfg_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;
   logic module_enable, transmit_enable, receive_enable;
   logic [LCTL_W-1:0] lctl;
   logic [DIV_W-1:0] baud_divisor;
   logic [2:0] last_bit;
   logic busy;

   ufb_fifo_if #(.WIDTH(CHAR_W)) txf ();
   ufb_fifo_if #(.WIDTH(ENTRY_W)) rxf ();

   ufb_fifo #(.WIDTH(CHAR_W), .DEPTH(FIFO_DEPTH)) u_txf (
      .clk(CLK),
      .rst(RST),
      .port(txf)
   );
   ufb_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_rxf (
      .clk(CLK),
      .rst(RST),
      .port(rxf)
   );

   assign module_enable = ctl_reg[CTL_EN];
   assign transmit_enable = ctl_reg[CTL_TX];
   assign receive_enable = ctl_reg[CTL_RX];
   assign lctl = cfg_reg[LCTL_W-1:0];
   assign baud_divisor = cfg_reg[CFG_W-1:LCTL_W];
   assign last_bit = MIN_LAST_BIT + 3'(lctl[LC_WLEN +: 2]);
   assign txf.single = !lctl[LC_FIFO];
   assign rxf.single = !lctl[LC_FIFO];

   always_comb begin
      ctl_next = ctl_reg;
      idiv_next = idiv_reg;
      fdiv_next = fdiv_reg;
      cfg_next = cfg_reg;
      rdata_next = '0;
      txf.push = 1'b0;
      txf.push_data = WDATA[CHAR_W-1:0];
      rxf.pop = 1'b0;
      if (WR) begin
         case (ADDR)
            OFF_DATA: txf.push = 1'b1;
            OFF_IDIV: idiv_next = WDATA[INT_W-1:0];
            OFF_FDIV: fdiv_next = WDATA[FRAC_W-1:0];
            OFF_LCTL: cfg_next = {idiv_reg, fdiv_reg,
                                  WDATA[LCTL_W-1:0]};
            OFF_CTL: begin
               ctl_next = '0;
               ctl_next[CTL_EN] = WDATA[CTL_EN];
               ctl_next[CTL_TX] = WDATA[CTL_TX];
               ctl_next[CTL_RX] = WDATA[CTL_RX];
            end
            default: ;
         endcase
      end
      if (RD) begin
         case (ADDR)
            OFF_DATA: begin
               rxf.pop = 1'b1;
               if (!rxf.empty) begin
                  rdata_next[ENTRY_W-1:0] = rxf.pop_data;
               end
            end
            OFF_FLAG: begin
               rdata_next[FL_BUSY] = busy;
               rdata_next[FL_RXFE] = rxf.empty;
               rdata_next[FL_TXFF] = txf.full;
               rdata_next[FL_RXFF] = rxf.full;
               rdata_next[FL_TXFE] = txf.empty;
            end
            OFF_IDIV: rdata_next[INT_W-1:0] = idiv_reg;
            OFF_FDIV: rdata_next[FRAC_W-1:0] = fdiv_reg;
            OFF_LCTL: rdata_next[LCTL_W-1:0] = lctl;
            OFF_CTL: rdata_next = ctl_reg;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         ctl_reg <= CTL_RST;
         idiv_reg <= '0;
         fdiv_reg <= '0;
         cfg_reg <= '0;
         rdata_reg <= '0;
      end else begin
         ctl_reg <= ctl_next;
         idiv_reg <= idiv_next;
         fdiv_reg <= fdiv_next;
         cfg_reg <= cfg_next;
         rdata_reg <= rdata_next;
      end
   end

   assign RDATA = rdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Fractional baud generator: divisor counted in 1/64 clock units
   logic [DIV_W:0] acc_reg, acc_next, acc_sum;
   logic tick_reg, tick_next;

   always_comb begin
      acc_sum = acc_reg + FRAC_STEP;
      acc_next = '0;
      tick_next = 1'b0;
      if (baud_divisor[DIV_W-1:FRAC_W] != '0) begin
         if (acc_sum >= {1'b0, baud_divisor}) begin
            acc_next = acc_sum - {1'b0, baud_divisor};
            tick_next = 1'b1;
         end else begin
            acc_next = acc_sum;
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         acc_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         tick_reg <= tick_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmitter
   ufb_state_t tx_state_reg, tx_state_next;
   logic [3:0] tx_tick_reg, tx_tick_next;
   logic [2:0] tx_bit_reg, tx_bit_next;
   logic [CHAR_W-1:0] tx_shift_reg, tx_shift_next;
   logic tx_par_reg, tx_par_next;
   logic tx_out_reg, tx_out_next;

   assign busy = !txf.empty || (tx_state_reg != ST_IDLE);

   always_comb begin
      tx_state_next = tx_state_reg;
      tx_tick_next = tx_tick_reg;
      tx_bit_next = tx_bit_reg;
      tx_shift_next = tx_shift_reg;
      tx_par_next = tx_par_reg;
      tx_out_next = tx_out_reg;
      txf.pop = 1'b0;
      case (tx_state_reg)
         ST_IDLE: begin
            tx_out_next = 1'b1;
            if (!txf.empty && module_enable && transmit_enable) begin
               txf.pop = 1'b1;
               tx_shift_next = txf.pop_data;
               tx_par_next = parity_of(txf.pop_data, last_bit,
                                       lctl[LC_EPS], lctl[LC_SPS]);
               tx_tick_next = '0;
               tx_out_next = 1'b0;
               tx_state_next = ST_START;
            end
         end
         default: begin
            // Frame runs to its end regardless of the enables
            if (tick_reg) begin
               tx_tick_next = tx_tick_reg + 4'h1;
               if (tx_tick_reg == LAST_TICK) begin
                  case (tx_state_reg)
                     ST_START: begin
                        tx_out_next = tx_shift_reg[0];
                        tx_bit_next = '0;
                        tx_state_next = ST_DATA;
                     end
                     ST_DATA: begin
                        if (tx_bit_reg == last_bit) begin
                           if (lctl[LC_PEN]) begin
                              tx_out_next = tx_par_reg;
                              tx_state_next = ST_PAR;
                           end else begin
                              tx_out_next = 1'b1;
                              tx_bit_next = '0;
                              tx_state_next = ST_STOP;
                           end
                        end else begin
                           tx_shift_next = tx_shift_reg >> 1;
                           tx_out_next = tx_shift_reg[1];
                           tx_bit_next = tx_bit_reg + 3'h1;
                        end
                     end
                     ST_PAR: begin
                        tx_out_next = 1'b1;
                        tx_bit_next = '0;
                        tx_state_next = ST_STOP;
                     end
                     default: begin
                        if (lctl[LC_STP2] && tx_bit_reg == '0) begin
                           tx_bit_next = 3'h1;
                        end else begin
                           tx_state_next = ST_IDLE;
                        end
                     end
                  endcase
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         tx_state_reg <= ST_IDLE;
         tx_tick_reg <= '0;
         tx_bit_reg <= '0;
         tx_shift_reg <= '0;
         tx_par_reg <= 1'b0;
         tx_out_reg <= 1'b1;
      end else begin
         tx_state_reg <= tx_state_next;
         tx_tick_reg <= tx_tick_next;
         tx_bit_reg <= tx_bit_next;
         tx_shift_reg <= tx_shift_next;
         tx_par_reg <= tx_par_next;
         tx_out_reg <= tx_out_next;
      end
   end

   assign SERIAL_OUT_PIN = tx_out_reg;

   ////////////////////////////////////////////////////////////////////////
   // Receiver
   logic rx_meta_reg, rx_sync_reg, rx_prev_reg;
   ufb_state_t rx_state_reg, rx_state_next;
   logic [3:0] rx_tick_reg, rx_tick_next;
   logic [2:0] rx_bit_reg, rx_bit_next;
   logic [CHAR_W-1:0] rx_data_reg, rx_data_next;
   logic rx_pe_reg, rx_pe_next;
   logic rx_zero_reg, rx_zero_next;
   logic rx_ovr_reg, rx_ovr_next;
   logic rx_fe, rx_be;

   always_comb begin
      rx_state_next = rx_state_reg;
      rx_tick_next = rx_tick_reg;
      rx_bit_next = rx_bit_reg;
      rx_data_next = rx_data_reg;
      rx_pe_next = rx_pe_reg;
      rx_zero_next = rx_zero_reg;
      rx_ovr_next = rx_ovr_reg;
      rx_fe = !rx_sync_reg;
      rx_be = !rx_sync_reg && rx_zero_reg;
      rxf.push = 1'b0;
      rxf.push_data = {rx_ovr_reg, rx_be, rx_pe_reg, rx_fe, rx_data_reg};
      case (rx_state_reg)
         ST_IDLE: begin
            if (rx_prev_reg && !rx_sync_reg && module_enable
                && receive_enable) begin
               rx_tick_next = '0;
               rx_state_next = ST_START;
            end
         end
         ST_START: begin
            if (tick_reg) begin
               rx_tick_next = rx_tick_reg + 4'h1;
               if (rx_tick_reg == MID_TICK) begin
                  rx_tick_next = '0;
                  rx_bit_next = '0;
                  rx_data_next = '0;
                  rx_pe_next = 1'b0;
                  rx_zero_next = 1'b1;
                  rx_state_next = rx_sync_reg ? ST_IDLE : ST_DATA;
               end
            end
         end
         default: begin
            if (tick_reg) begin
               rx_tick_next = rx_tick_reg + 4'h1;
               if (rx_tick_reg == LAST_TICK) begin
                  rx_zero_next = rx_zero_reg && !rx_sync_reg;
                  case (rx_state_reg)
                     ST_DATA: begin
                        rx_data_next[rx_bit_reg] = rx_sync_reg;
                        rx_bit_next = rx_bit_reg + 3'h1;
                        if (rx_bit_reg == last_bit) begin
                           rx_state_next = lctl[LC_PEN] ? ST_PAR
                                                        : ST_STOP;
                        end
                     end
                     ST_PAR: begin
                        rx_pe_next = rx_sync_reg != parity_of(rx_data_reg,
                           last_bit, lctl[LC_EPS], lctl[LC_SPS]);
                        rx_state_next = ST_STOP;
                     end
                     default: begin
                        rxf.push = 1'b1;
                        if (rxf.full) begin
                           rx_ovr_next = 1'b1;
                        end else begin
                           rx_ovr_next = 1'b0;
                        end
                        rx_state_next = ST_IDLE;
                     end
                  endcase
               end
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         rx_meta_reg <= 1'b1;
         rx_sync_reg <= 1'b1;
         rx_prev_reg <= 1'b1;
         rx_state_reg <= ST_IDLE;
         rx_tick_reg <= '0;
         rx_bit_reg <= '0;
         rx_data_reg <= '0;
         rx_pe_reg <= 1'b0;
         rx_zero_reg <= 1'b0;
         rx_ovr_reg <= 1'b0;
      end else begin
         rx_meta_reg <= SERIAL_IN_PIN;
         rx_sync_reg <= rx_meta_reg;
         rx_prev_reg <= rx_sync_reg;
         rx_state_reg <= rx_state_next;
         rx_tick_reg <= rx_tick_next;
         rx_bit_reg <= rx_bit_next;
         rx_data_reg <= rx_data_next;
         rx_pe_reg <= rx_pe_next;
         rx_zero_reg <= rx_zero_next;
         rx_ovr_reg <= rx_ovr_next;
      end
   end
endmodule

// ---- bench/ufb_top_asserts.sv ----
`timescale 1ns/1ps
module ufb_top_asserts (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [ufb_pkg::ADDR_W-1:0] ADDR,
   input wire logic [ufb_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [ufb_pkg::DATA_W-1:0] RDATA,
   input wire logic SERIAL_IN_PIN,
   input wire logic SERIAL_OUT_PIN
);
   import ufb_pkg::*;
   logic [5:0] low_cnt_reg;
   logic [5:0] low_cnt_next;
   logic ctl_wr_reg;
   logic ctl_wr_next;
   logic flag_rd;

   ////////////////////////////////////////////////////////////////////////
   // Length of the current low run on the line, saturating
   always_comb begin
      low_cnt_next = low_cnt_reg;
      if (SERIAL_OUT_PIN) begin
         low_cnt_next = 6'h00;
      end else if (low_cnt_reg != 6'h3F) begin
         low_cnt_next = low_cnt_reg + 6'h01;
      end
      ctl_wr_next = ctl_wr_reg | (WR && ADDR == OFF_CTL);
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         low_cnt_reg <= 6'h00;
         ctl_wr_reg <= 1'b0;
      end else begin
         low_cnt_reg <= low_cnt_next;
         ctl_wr_reg <= ctl_wr_next;
      end
   end

   assign flag_rd = RD && ADDR == OFF_FLAG;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   AST_CTL_RESET: assert property (
      RD && ADDR == OFF_CTL && !ctl_wr_reg |=> RDATA == CTL_RST)
      else $error("control register not at reset value");
   AST_OUT_IDLE: assert property (
      $fell(RST) |-> SERIAL_OUT_PIN)
      else $error("serial output not idle after reset");
   AST_BIT_LEN: assert property (
      $rose(SERIAL_OUT_PIN) |-> low_cnt_reg >= 6'h10)
      else $error("low run on serial output shorter than a bit");
   AST_BUSY_LOW: assert property (
      flag_rd && !SERIAL_OUT_PIN |=> RDATA[FL_BUSY])
      else $error("busy clear while a frame is on the line");
   AST_TXFE_BUSY: assert property (
      flag_rd |=> RDATA[FL_BUSY] || RDATA[FL_TXFE])
      else $error("transmit queue holds data but busy clear");
   AST_TX_FLAGS: assert property (
      flag_rd |=> !(RDATA[FL_TXFE] && RDATA[FL_TXFF]))
      else $error("transmit queue both empty and full");
   AST_RX_FLAGS: assert property (
      flag_rd |=> !(RDATA[FL_RXFE] && RDATA[FL_RXFF]))
      else $error("receive queue both empty and full");
   AST_ENTRY_W: assert property (
      RD && ADDR == OFF_DATA |=> RDATA[31:12] == 20'h0_0000)
      else $error("receive entry wider than twelve bits");

   cover property ($fell(SERIAL_OUT_PIN));
   cover property ($fell(SERIAL_IN_PIN));
   cover property (RD && ADDR == OFF_DATA);
endmodule

bind ufb_top ufb_top_asserts u_ufb_top_asserts (
   .CLK(CLK),
   .RST(RST),
   .ADDR(ADDR),
   .WDATA(WDATA),
   .WR(WR),
   .RD(RD),
   .RDATA(RDATA),
   .SERIAL_IN_PIN(SERIAL_IN_PIN),
   .SERIAL_OUT_PIN(SERIAL_OUT_PIN)
);

// ---- bench/ufb_remote.sv ----
`timescale 1ns/1ps
module ufb_remote (
   input wire logic clk,
   input wire logic line_in,
   output logic line_out
);
   int bit_clk;

   initial begin
      line_out = 1'b1;
      bit_clk = 16;
   end

   // Raw frame, bit 0 first; the line returns to idle high after it
   task automatic send(input logic [15:0] frame, input int len,
                       input int per);
      for (int k = 0; k < len; k++) begin
         @(posedge clk);
         line_out <= frame[k];
         repeat (per - 1) @(posedge clk);
      end
      @(posedge clk);
      line_out <= 1'b1;
   endtask

   // Samples each bit in its middle, away from the launching edge
   task automatic capture(input int len, output logic [15:0] frame,
                          output bit ok);
      int n;
      frame = 16'h0000;
      ok = 1'b0;
      for (n = 0; n < 20000 && line_in; n++) @(negedge clk);
      if (!line_in) begin
         ok = 1'b1;
         repeat (bit_clk / 2) @(negedge clk);
         for (n = 0; n < len; n++) begin
            frame[n] = line_in;
            if (n < len - 1) repeat (bit_clk) @(negedge clk);
         end
      end
   endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
   import ufb_pkg::*;
   typedef struct {
      logic [7:0] lc;
      logic [7:0] ch;
      logic [31:0] rx;
   } ufb_row_t;
   localparam logic [31:0] BUSY = 32'h0000_0001 << FL_BUSY;
   localparam logic [31:0] RXFE = 32'h0000_0001 << FL_RXFE;
   localparam logic [31:0] TXFF = 32'h0000_0001 << FL_TXFF;
   localparam logic [31:0] TXFE = 32'h0000_0001 << FL_TXFE;
   logic CLK, RST, WR, RD, SERIAL_IN_PIN, SERIAL_OUT_PIN;
   logic [ADDR_W-1:0] ADDR;
   logic [DATA_W-1:0] WDATA, RDATA, f;
   logic [15:0] fr, got;
   int n_fail = 0;
   int samples_checked = 0;
   int len, i;
   bit ok;
   ufb_row_t rows [8] = '{
      '{8'h60, 8'hA5, 32'h0000_00A5}, '{8'h46, 8'h35, 32'h0000_0035},
      '{8'h2A, 8'h2C, 32'h0000_002C}, '{8'h08, 8'h13, 32'h0000_0013},
      '{8'hE6, 8'h81, 32'h0000_0081}, '{8'hE2, 8'h7F, 32'h0000_007F},
      '{8'h72, 8'h00, 32'h0000_0000}, '{8'h4E, 8'hFF, 32'h0000_007F}};

   ufb_top u_ufb_top (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .SERIAL_IN_PIN(SERIAL_IN_PIN),
      .SERIAL_OUT_PIN(SERIAL_OUT_PIN));
   ufb_remote u_ufb_remote (.clk(CLK), .line_in(SERIAL_OUT_PIN),
      .line_out(SERIAL_IN_PIN));

   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_line(input logic [15:0] g, input logic [15:0] e);
      if (!ok) begin
         n_fail++;
         conclude();
      end
      chk_reg({16'h0000, g}, {16'h0000, e});
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask

   task automatic poll(input logic [31:0] m, input logic [31:0] v);
      int k;
      for (k = 0; k < 500; k++) begin
         rd(OFF_FLAG, f);
         if ((f & m) === v) break;
      end
      chk_reg(f & m, v);
      if (k == 500) conclude();
   endtask

   // Expected wire image of one character
   function automatic logic [15:0] mk(input logic [7:0] lc,
                                      input logic [7:0] ch, output int n);
      logic [15:0] w;
      logic p;
      w = 16'h0000;
      p = 1'b0;
      for (int k = 0; k < 5 + lc[LC_WLEN+:2]; k++) begin
         w[1+k] = ch[k];
         p = p ^ ch[k];
      end
      n = 6 + lc[LC_WLEN+:2];
      if (lc[LC_PEN]) begin
         w[n] = lc[LC_SPS] ? ~lc[LC_EPS] : (lc[LC_EPS] ? p : ~p);
         n++;
      end
      w[n] = 1'b1;
      n = n + 1 + lc[LC_STP2];
      w[n-1] = 1'b1;
      return w;
   endfunction

   task automatic cfg(input logic [15:0] idv, input logic [7:0] lc);
      wr(OFF_CTL, 32'h0000_0000);
      wr(OFF_IDIV, {16'h0000, idv});
      wr(OFF_FDIV, 32'h0000_0000);
      wr(OFF_LCTL, {24'h00_0000, lc});
      wr(OFF_CTL, 32'h0000_0301);
   endtask

   task automatic txc(input logic [7:0] lc, input logic [7:0] ch);
      fr = mk(lc, ch, len);
      fork
         u_ufb_remote.capture(len, got, ok);
         wr(OFF_DATA, {24'h00_0000, ch});
      join
      chk_line(got, fr);
   endtask

   task automatic rxc(input logic [15:0] w, input int n,
                      input logic [31:0] e);
      u_ufb_remote.send(w, n, 16);
      poll(RXFE, 32'h0000_0000);
      rd(OFF_DATA, f);
      chk_reg(f, e);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      RST = 1'b1;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 8'h00;
      WDATA = 32'h0000_0000;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      foreach (rows[r]) begin
         cfg(16'h0001, rows[r].lc);
         txc(rows[r].lc, rows[r].ch);
         poll(BUSY | TXFE, TXFE);
         fr = mk(rows[r].lc, rows[r].ch, len);
         rxc(fr, len, rows[r].rx);
      end
      cfg(16'h0001, 8'h46);
      fr = mk(8'h46, 8'h35, len);
      rxc(fr ^ 16'h0100, len, 32'h0000_0235);
      rxc(fr ^ 16'h0200, len, 32'h0000_0135);
      rxc(16'h0000, 11, 32'h0000_0500);
      u_ufb_remote.send(16'h0000, 1, 4);
      repeat (40) @(posedge CLK);
      rxc(fr, len, 32'h0000_0035);
      poll(RXFE, RXFE);
      fr = mk(8'h46, 8'h11, len);
      u_ufb_remote.send(fr, len, 16);
      fr = mk(8'h46, 8'h22, len);
      u_ufb_remote.send(fr, len, 16);
      rd(OFF_DATA, f);
      chk_reg(f, 32'h0000_0011);
      fr = mk(8'h46, 8'h33, len);
      rxc(fr, len, 32'h0000_0833);
      // Fraction staged only; the active rate must not move yet
      cfg(16'h0001, 8'h60);
      wr(OFF_CTL, 32'h0000_0000);
      wr(OFF_FDIV, 32'h0000_0020);
      wr(OFF_CTL, 32'h0000_0301);
      txc(8'h60, 8'hC3);
      poll(BUSY, 32'h0000_0000);
      wr(OFF_CTL, 32'h0000_0000);
      wr(OFF_IDIV, 32'h0000_0001);
      wr(OFF_LCTL, 32'h0000_0060);
      wr(OFF_CTL, 32'h0000_0301);
      u_ufb_remote.bit_clk = 24;
      txc(8'h60, 8'h3C);
      poll(BUSY, 32'h0000_0000);
      u_ufb_remote.bit_clk = 16;
      cfg(16'h0001, 8'h60);
      fork
         u_ufb_remote.capture(10, got, ok);
         begin
            wr(OFF_DATA, 32'h0000_005A);
            repeat (30) @(posedge CLK);
            wr(OFF_CTL, 32'h0000_0300);
            rd(OFF_FLAG, f);
            chk_reg(f & BUSY, BUSY);
         end
      join
      fr = mk(8'h60, 8'h5A, len);
      chk_line(got, fr);
      poll(BUSY, 32'h0000_0000);
      wr(OFF_DATA, 32'h0000_0001);
      rd(OFF_FLAG, f);
      chk_reg(f & (BUSY | TXFF | TXFE), BUSY | TXFF);
      fork
         u_ufb_remote.capture(10, got, ok);
         wr(OFF_CTL, 32'h0000_0301);
      join
      fr = mk(8'h60, 8'h01, len);
      chk_line(got, fr);
      poll(BUSY, 32'h0000_0000);
      wr(OFF_CTL, 32'h0000_0000);
      wr(OFF_LCTL, 32'h0000_0070);
      for (i = 0; i < 17; i++) wr(OFF_DATA, i);
      rd(OFF_FLAG, f);
      chk_reg(f & TXFF, TXFF);
      for (i = 0; i < 16; i++) begin
         fork
            u_ufb_remote.capture(10, got, ok);
            if (i == 0) wr(OFF_CTL, 32'h0000_0301);
         join
         fr = mk(8'h70, i[7:0], len);
         chk_line(got, fr);
      end
      rd(OFF_FLAG, f);
      chk_reg(f & TXFE, TXFE);
      @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      rd(OFF_CTL, f);
      chk_reg(f, CTL_RST);
      rd(OFF_FLAG, f);
      chk_reg(f, TXFE | RXFE);
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, f);
      chk_reg(f, 32'h0000_0000);
      chk_reg({31'h0000_0000, SERIAL_OUT_PIN}, 32'h0000_0001);
      conclude();
   end
endmodule
